// File: dv/step_ctrl_model.sv
// controller model driving step pulses and direction
`timescale 1ns/1ps
module step_ctrl_model
  import step_dir_pkg::*;
(
  // burst request, cmd is {slow, direction, count}, and the pins
  input  wire logic       sys_clk,
  input  wire logic       go,
  input  wire logic [9:0] cmd,
  output logic            step_pulse_in = 1'h0,
  output logic            dir_in = 1'h0,
  output logic            done = 1'h0
);
  // direction first, then pulses at the rated rate or half of it
  always @(posedge sys_clk)
    if (!go) done <= 1'h0;
    else if (!done) begin
      dir_in <= cmd[8];
      repeat (DIR_SETUP_CYC) @(posedge sys_clk);
      repeat (cmd[7:0]) begin
        step_pulse_in <= 1'h1;
        repeat ((STEP_MIN_CYC / 2) << cmd[9]) @(posedge sys_clk);
        step_pulse_in <= 1'h0;
        repeat ((STEP_MIN_CYC / 2) << cmd[9]) @(posedge sys_clk);
      end
      done <= 1'h1;
    end
endmodule

// File: dv/step_dir_sva.sv
// port assertions for the step input stage
`timescale 1ns/1ps
module step_dir_sva
  import step_dir_pkg::*;
#(parameter int unsigned POS_W = 32) (
  // clock, reset, inputs and outputs
  input wire logic             sys_clk,
  input wire logic             rst,
  input wire logic             step_pulse_in,
  input wire logic [3:0]       resolution_switches,
  input wire logic             edge_select_switch,
  input wire logic             avs_write,
  input wire logic [POS_W-1:0] target_position,
  input wire logic [RES_W-1:0] steps_per_rev,
  input wire logic             step_strobe,
  input wire logic             step_forward
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // switches settled for six edges
  sequence held;
    $stable(resolution_switches)[*6];
  endsequence
  AST_ONE_STROBE: assert property (step_strobe |=> !step_strobe)
    else $error("strobe too long");
  AST_EDGE: assert property (step_strobe |-> step_pulse_in !=
    edge_select_switch && $past(step_pulse_in, 6) == edge_select_switch)
    else $error("wrong edge");
  AST_UP: assert property (step_strobe && step_forward &&
    !$past(avs_write) |-> target_position == $past(target_position) + 1'h1)
    else $error("no step up");
  AST_DOWN: assert property (step_strobe && !step_forward &&
    !$past(avs_write) |-> target_position == $past(target_position) - 1'h1)
    else $error("no step down");
  AST_HOLD: assert property (!step_strobe && !$past(avs_write)
    |-> $stable(target_position)) else $error("position moved");
  AST_RES_HI: assert property (held ##0 (resolution_switches[3] &&
    resolution_switches != 4'hF) |->
    steps_per_rev == RES_HI[~resolution_switches[2:0]]) else $error("hi");
  AST_RES_LO: assert property (held ##0 !resolution_switches[3] |->
    steps_per_rev == RES_LO[~resolution_switches[2:0]]) else $error("lo");
  AST_RES_SW: assert property (held ##0 resolution_switches == 4'hF |->
    steps_per_rev inside {[SOFT_RES_MIN:SOFT_RES_MAX]}) else $error("soft");
  // main scenarios
  cover property (step_strobe && step_forward);
  cover property (step_strobe && !step_forward);
  cover property (held ##0 resolution_switches == 4'hF);
endmodule
bind step_dir_input step_dir_sva #(.POS_W(POS_W)) i_step_dir_sva (.*);

// File: dv/tb_top.sv
// bench for the step and direction input stage
`timescale 1ns/1ps
module tb_top
  import step_dir_pkg::*;
;
  // bench signals, inputs valued at time zero
  logic        sys_clk = 1'h0, rst = 1'h1, go = 1'h0, avs_read = 1'h0;
  logic        avs_write = 1'h0, edge_select_switch = 1'h0;
  logic        reverse_switch = 1'h0, done, dir_in, step_pulse_in;
  logic        avs_waitrequest, step_strobe, step_forward;
  logic [3:0]  resolution_switches = 4'h0, avs_address = 4'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [9:0]  cmd = 10'h0;
  logic [15:0] steps_per_rev;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, target_position, q;
  int          mismatches, check_count;
  // block and controller model
  step_dir_input i_step_dir_input (.*);
  step_ctrl_model i_step_ctrl_model (.*);
  initial forever #10 sys_clk = ~sys_clk;
  // verdict
  task close_out;
    if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one comparison
  task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  // bus transfer held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge sys_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'h0 && ++n < 50);
    if (n >= 50) mismatches++;
    if (n >= 50) close_out;
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
  endtask
  // every switch pattern
  task t_res;
    logic [15:0] e;
    for (int i = 0; i < 16; i++) begin
      resolution_switches <= i[3:0];
      repeat (8) @(posedge sys_clk);
      e = i == 15 ? SOFT_RES_RST : i[3] ? RES_HI[~i[2:0]] : RES_LO[~i[2:0]];
      cmp("spr", {16'h0, e}, {16'h0, steps_per_rev});
      bus(1'h0, ADDR_ACTIVE_RES, 32'h0);
      cmp("active", {16'h0, e}, q);
    end
  endtask
  // soft resolution at and past its bounds
  task t_soft;
    logic [31:0] v [4] = '{32'h4, 32'h3, 32'hC800, 32'hC801};
    logic [31:0] e [4] = '{32'h4, 32'h4, 32'hC800, 32'hC800};
    for (int i = 0; i < 4; i++) begin
      bus(1'h1, ADDR_SOFT_RES, v[i]);
      repeat (6) @(posedge sys_clk);
      cmp("spr", e[i], {16'h0, steps_per_rev});
    end
  endtask
  // burst of steps, position moves by d
  task t_move(input logic es, rv, dl, sl, input logic [7:0] n, input int d);
    logic [31:0] p0;
    int k;
    p0 = target_position;
    edge_select_switch <= es;
    reverse_switch <= rv;
    cmd <= {sl, dl, n};
    go <= 1'h1;
    for (k = 0; k < 9000 && done !== 1'h1; k++) @(posedge sys_clk);
    if (k >= 9000) mismatches++;
    if (k >= 9000) close_out;
    go <= 1'h0;
    repeat (8) @(posedge sys_clk);
    cmp("pos", p0 + d, target_position);
    cmp("fwd", {31'h0, dl ^ rv}, {31'h0, step_forward});
  endtask
  // position read, clear, unmapped read, switch readback
  task t_clr;
    bus(1'h0, ADDR_POSITION, 32'h0);
    cmp("pos reg", 32'h4, q);
    bus(1'h1, ADDR_CTRL, 32'h1);
    repeat (2) @(posedge sys_clk);
    cmp("pos", 32'h0, target_position);
    bus(1'h0, 4'h2, 32'h0);
    cmp("unmapped", UNMAPPED_READ, q);
    bus(1'h0, ADDR_CTRL, 32'h0);
    cmp("ctrl", 32'h3F, q);
  endtask
  // reset, then the scenarios
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'h0;
    t_res;
    t_soft;
    t_move(1'h0, 1'h0, 1'h1, 1'h0, 8'h5, 5);
    t_move(1'h1, 1'h0, 1'h0, 1'h0, 8'h3, -3);
    t_move(1'h0, 1'h1, 1'h1, 1'h0, 8'h2, -2);
    t_move(1'h1, 1'h1, 1'h0, 1'h1, 8'h4, 4);
    t_clr;
    close_out;
  end
endmodule

// File: logic/step_dir_input.sv
// step and direction input stage with resolution select
`timescale 1ns/1ps

// Notes on behaviour
// - each active edge of the step input is one step command
// - steps up to 200 kHz are all counted
// - all four resolution switches on selects the software resolution
// - software resolution accepts 4 to 51200 inclusive
// - any resolution switch off selects the switch-decoded resolution
// - switch four on: index 1..7 gives 800 to 51200
// - switch four off: index 0..7 gives 1000 to 40000
// - edge switch off counts rising edges, on counts falling edges
// - toggling the reverse switch inverts direction mapping
// - the two direction levels mean opposite rotation senses
module step_dir_input
  import step_dir_pkg::*;
#(
  parameter int unsigned POS_W = 32
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // motion controller pins
  input  wire logic        step_pulse_in,
  input  wire logic        dir_in,
  // configuration switches, high means on
  input  wire logic [3:0]  resolution_switches,
  input  wire logic        edge_select_switch,
  input  wire logic        reverse_switch,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // position outputs
  output logic [POS_W-1:0] target_position,
  output logic [RES_W-1:0] steps_per_rev,
  output logic             step_strobe,
  output logic             step_forward
);

  // ***************************************************
  // elaboration checks
  // ***************************************************
  initial begin
    if (POS_W < 17 || POS_W > 32)
      $error("POS_W must be 17 to 32");
    if (STEP_MIN_CYC < 8)
      $error("clock too slow for the step rate");
    if (RES_W != 16)
      $error("resolution width must be 16");
    if (DIR_SETUP_CYC < 4)
      $error("clock too slow for the direction setup");
    // switch tables must rise with the index
    for (int i = 2; i < 8; i++) begin
      if (RES_HI[i] <= RES_HI[i-1])
        $error("table for switch four on not ascending");
    end
    for (int i = 1; i < 8; i++) begin
      if (RES_LO[i] <= RES_LO[i-1])
        $error("table for switch four off not ascending");
    end
    // table ends inside the software range
    if (RES_HI[1] < SOFT_RES_MIN || RES_HI[7] > SOFT_RES_MAX)
      $error("table for switch four on out of range");
    if (RES_LO[0] < SOFT_RES_MIN || RES_LO[7] > SOFT_RES_MAX)
      $error("table for switch four off out of range");
    if (SOFT_RES_RST < SOFT_RES_MIN || SOFT_RES_RST > SOFT_RES_MAX)
      $error("software resolution reset value out of range");
  end

  // ***************************************************
  // input synchronisers
  // ***************************************************
  // every pin is asynchronous to sys_clk; a bare edge
  // detector on a pin could see a metastable level and
  // report two edges or none, so edges are taken only
  // from the second flip-flop of each synchroniser.
  // the switches share the same two-stage treatment.
  logic step_lvl;
  logic step_rise;
  logic step_fall;
  logic dir_lvl;
  logic [3:0] sw_meta_q;
  logic [3:0] sw_q;
  logic [1:0] cfg_meta_q;
  logic [1:0] cfg_q;

  sync_edge u_step_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin_in  (step_pulse_in),
    .level   (step_lvl),
    .rise    (step_rise),
    .fall    (step_fall)
  );

  sync_edge u_dir_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin_in  (dir_in),
    .level   (dir_lvl),
    .rise    (),
    .fall    ()
  );

  // switches are pins too, two stages each
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sw_meta_q  <= 4'h0;
      sw_q       <= 4'h0;
      cfg_meta_q <= 2'h0;
      cfg_q      <= 2'h0;
    end else begin
      sw_meta_q  <= resolution_switches;
      sw_q       <= sw_meta_q;
      cfg_meta_q <= {reverse_switch, edge_select_switch};
      cfg_q      <= cfg_meta_q;
    end
  end

  // ***************************************************
  // resolution select
  // ***************************************************
  // the decoded value is registered so that a switch
  // bounce shows at most one cycle of a neighbour
  // value; index 0 of the upper table is never used,
  // since all switches on selects the software value.
  logic [15:0] soft_res_q;
  logic [2:0]  res_index;
  logic [15:0] res_d;
  logic [15:0] res_q;

  // switch one off adds 1, two adds 2, three adds 4
  assign res_index = ~sw_q[2:0];

  always_comb begin
    if (sw_q == 4'hF)
      res_d = soft_res_q;
    else if (sw_q[3])
      res_d = RES_HI[res_index];
    else
      res_d = RES_LO[res_index];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      res_q <= SOFT_RES_RST;
    else
      res_q <= res_d;
  end

  assign steps_per_rev = res_q;

  // ***************************************************
  // step acceptance and direction
  // ***************************************************
  // direction is read at the step edge through the same
  // two-stage delay as the step, so the setup time that
  // the controller keeps at the pins holds inside too.
  logic step_hit;
  logic fwd;

  // one-cycle edge pulse; 250 clocks per step at 200 kHz
  assign step_hit = cfg_q[0] ? step_fall : step_rise;
  // dir read in the cycle of the step edge
  assign fwd = dir_lvl ^ cfg_q[1];

  // ***************************************************
  // target position counter
  // ***************************************************
  // the counter wraps in two's complement; a clear
  // written in the cycle of a step wins, the step is
  // lost, which a user clearing while moving must know.
  logic [POS_W-1:0] pos_q;
  logic [POS_W-1:0] pos_d;
  logic             clr_pos;
  logic             strobe_q;
  logic             fwd_q;

  always_comb begin
    pos_d = pos_q;
    if (clr_pos)
      pos_d = '0;
    else if (step_hit && fwd)
      pos_d = pos_q + POS_W'(1);
    else if (step_hit)
      pos_d = pos_q - POS_W'(1);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      pos_q <= '0;
    else
      pos_q <= pos_d;
  end

  // registered step report for the servo loop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strobe_q <= 1'b0;
      fwd_q    <= 1'b0;
    end else begin
      strobe_q <= step_hit;
      if (step_hit)
        fwd_q <= fwd;
    end
  end

  assign target_position = pos_q;
  assign step_strobe     = strobe_q;
  assign step_forward    = fwd_q;

  // ***************************************************
  // avalon-mm register slave
  // ***************************************************
  // writes never wait; reads wait one cycle so that
  // the read data leave a flip-flop. read and write
  // high together is treated as a read only.
  logic        wr_cyc;
  logic        sel_ctrl;
  logic        sel_soft;
  logic        soft_in_range;
  logic        rd_done_q;
  logic [31:0] rdata_q;
  logic [15:0] wr_res;

  // writes complete at once, reads after one wait cycle
  assign avs_waitrequest = avs_read & ~rd_done_q;
  assign wr_cyc          = avs_write & ~avs_read;
  assign wr_res          = avs_writedata[15:0];

  // address decode, one select per written register
  assign sel_ctrl      = avs_address == ADDR_CTRL;
  assign sel_soft      = avs_address == ADDR_SOFT_RES;
  // range test kept apart, a bad value keeps the old
  assign soft_in_range = wr_res >= SOFT_RES_MIN &&
                         wr_res <= SOFT_RES_MAX;

  // software resolution, out-of-range writes are ignored
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      soft_res_q <= SOFT_RES_RST;
    else if (wr_cyc && sel_soft &&
             avs_byteenable[1:0] == 2'h3 && soft_in_range)
      soft_res_q <= wr_res;
  end

  // writing the clear bit zeroes the position
  assign clr_pos = wr_cyc && sel_ctrl &&
                   avs_byteenable[0] && avs_writedata[CTRL_CLR_BIT];

  // read data captured in the wait cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_done_q <= 1'b0;
      rdata_q   <= 32'h0000_0000;
    end else begin
      rd_done_q <= avs_read & ~rd_done_q;
      if (avs_read && !rd_done_q) begin
        case (avs_address)
          ADDR_CTRL:       rdata_q <= {26'h0, cfg_q, sw_q};
          ADDR_SOFT_RES:   rdata_q <= {16'h0, soft_res_q};
          ADDR_ACTIVE_RES: rdata_q <= {16'h0, res_q};
          ADDR_POSITION:   rdata_q <= 32'(signed'(pos_q));
          default:         rdata_q <= UNMAPPED_READ;
        endcase
      end
    end
  end

  assign avs_readdata = rdata_q;

endmodule

// File: logic/step_dir_pkg.sv
// constants for the step and direction input stage
package step_dir_pkg;

  // ***************************************************
  // clock and timing
  // ***************************************************
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned STEP_MAX_HZ     = 200_000;
  localparam int unsigned STEP_MIN_CYC    = CLK_HZ / STEP_MAX_HZ;
  localparam int unsigned DIR_SETUP_NS    = 5000;
  localparam int unsigned CLK_PERIOD_NS   = 20;
  localparam int unsigned DIR_SETUP_CYC   = DIR_SETUP_NS / CLK_PERIOD_NS;

  // ***************************************************
  // register map, 32-bit words
  // ***************************************************
  localparam logic [3:0] ADDR_CTRL        = 4'h0;
  localparam logic [3:0] ADDR_SOFT_RES    = 4'h4;
  localparam logic [3:0] ADDR_ACTIVE_RES  = 4'h8;
  localparam logic [3:0] ADDR_POSITION    = 4'hC;
  localparam int unsigned CTRL_CLR_BIT    = 0;
  localparam int unsigned RES_W           = 16;
  localparam logic [15:0] SOFT_RES_RST    = 16'h0FA0;
  localparam logic [15:0] SOFT_RES_MIN    = 16'h0004;
  localparam logic [15:0] SOFT_RES_MAX    = 16'hC800;
  localparam logic [31:0] UNMAPPED_READ   = 32'h0000_0000;

  // ***************************************************
  // resolution tables
  // ***************************************************
  localparam logic [15:0] RES_HI [8] = '{
    16'h0000, 16'h0320, 16'h0640, 16'h0C80,
    16'h1900, 16'h3200, 16'h6400, 16'hC800};
  localparam logic [15:0] RES_LO [8] = '{
    16'h03E8, 16'h07D0, 16'h0FA0, 16'h1388,
    16'h1F40, 16'h2710, 16'h4E20, 16'h9C40};

endpackage

// File: logic/sync_edge.sv
// two-stage synchroniser with rise and fall detection
`timescale 1ns/1ps
module sync_edge (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // pin side
  input  wire logic pin_in,
  // synchronised level and edges
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // first stage is read only by the second
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // edges from synchronised samples only
  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;
  assign fall  = ~sync_q & prev_q;

endmodule
